// ---- logic/str_timer.sv ----
// Sixteen-bit timer/counter with reload, capture to preset and APB registers.
// Assumes pins synchronous to pclk and an APB master following the protocol.
`timescale 1ns/100ps

module str_timer (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic                  irq,
    input  str_pkg::str_pins_t    pins,
    output logic      [15:0]      count_value,
    output logic                  compare_mode_one
);

    str_pkg::str_state_t q;
    str_pkg::str_state_t s;

    logic       mc;
    logic       access;
    logic       wr;
    logic       rd;
    logic [9:0] widx;
    logic [1:0] isel;
    logic [1:0] rsel;
    logic       ps_ok;
    logic       tick;
    logic       ovf;
    logic       ev_edge;
    logic       trg_edge;
    logic       do_trig_rl;
    logic       cap;
    logic       ext_set;
    logic       wr_cnt;
    logic [7:0] rbyte;
    logic       hit;

    assign widx     = paddr[11:2];
    assign access   = psel & penable & q.pready;
    assign wr       = access & pwrite;
    assign rd       = access & ~pwrite;
    assign isel     = {q.ctrl[str_pkg::CB_IS_HI], q.ctrl[str_pkg::CB_IS_LO]};
    assign rsel     = {q.ctrl[str_pkg::CB_RL_HI], q.ctrl[str_pkg::CB_RL_LO]};
    assign mc       = (q.div == str_pkg::MC_LAST);
    assign ps_ok    = ~q.ctrl[str_pkg::CB_PS] | q.pre;
    assign wr_cnt   = wr & ((widx == str_pkg::IDX_CNT_L) | (widx == str_pkg::IDX_CNT_H));

    // Event and trigger edges come from two successive machine-cycle samples
    assign ev_edge  = mc & (isel == str_pkg::IS_EVENT)
                         & q.cnt_smp & ~pins.count_gate_pin;
    assign trg_edge = mc & (rsel == str_pkg::RL_TRIG)
                         & q.trg_smp & ~pins.reload_trigger_pin;
    assign do_trig_rl = mc & q.rl_pend & (rsel == str_pkg::RL_TRIG);
    assign ext_set  = trg_edge & q.ien[str_pkg::EB_EXT];
    assign ovf      = tick & (q.counter == str_pkg::CNT_ALL1);
    assign cap      = mc & (q.compare_capture_enable[1:0] == str_pkg::CE_CAP0)
                         & (q.ctrl[str_pkg::CB_EDGE] ? (~q.cc0_smp & pins.channel_zero_pin)
                                                     : (q.cc0_smp & ~pins.channel_zero_pin));

    always_comb begin
        case (isel)
            str_pkg::IS_TIMER: tick = mc & ps_ok;
            str_pkg::IS_GATED: tick = mc & ps_ok & pins.count_gate_pin;
            str_pkg::IS_EVENT: tick = mc & q.ev_pend;
            str_pkg::IS_STOP:  tick = 1'b0;
            default:           tick = 1'b0;
        endcase
    end

    // Read mux, evaluated in the setup cycle
    always_comb begin
        rbyte = 8'h00;
        hit   = 1'b1;
        case (widx)
            str_pkg::IDX_INTERRUPT_REQUEST_CONTROL: begin
                rbyte[str_pkg::IB_OVF] = q.overflow_flag;
                rbyte[str_pkg::IB_EXT] = q.external_reload_flag;
            end
            str_pkg::IDX_COMPARE_CAPTURE_ENABLE:  rbyte = q.compare_capture_enable;
            str_pkg::IDX_CC1L:  rbyte = q.ccr[0];
            str_pkg::IDX_CC1H:  rbyte = q.ccr[1];
            str_pkg::IDX_CC2L:  rbyte = q.ccr[2];
            str_pkg::IDX_CC2H:  rbyte = q.ccr[3];
            str_pkg::IDX_CC3L:  rbyte = q.ccr[4];
            str_pkg::IDX_CC3H:  rbyte = q.ccr[5];
            str_pkg::IDX_CTRL:  rbyte = q.ctrl;
            str_pkg::IDX_PRE_L: rbyte = q.preset[7:0];
            str_pkg::IDX_PRE_H: rbyte = q.preset[15:8];
            str_pkg::IDX_CNT_L: rbyte = q.counter[7:0];
            str_pkg::IDX_CNT_H: rbyte = q.counter[15:8];
            str_pkg::IDX_STAT:  rbyte = {6'h00, q.stat};
            str_pkg::IDX_MASK:  rbyte = {6'h00, q.mask};
            str_pkg::IDX_IEN:   rbyte = q.ien;
            str_pkg::IDX_BITOP: rbyte = 8'h00;
            default:            hit   = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end
    end

    always_comb begin
        s = q;
        s.div = mc ? 4'h0 : q.div + 4'h1;

        // APB answers one cycle after setup
        s.pready  = psel & ~penable;
        s.pslverr = psel & ~penable & ~hit;
        if (psel & ~penable) begin
            s.prdata = hit ? {24'h000000, rbyte} : 32'h00000000;
        end

        // Machine-cycle sampling of the pins
        if (mc) begin
            s.pre     = ~q.pre;
            s.cnt_smp = pins.count_gate_pin;
            s.trg_smp = pins.reload_trigger_pin;
            s.cc0_smp = pins.channel_zero_pin;
            s.ev_pend = ev_edge;
            s.rl_pend = trg_edge;
        end

        // Counter datapath
        if (do_trig_rl) begin
            s.counter = q.preset;
        end else if (ovf && rsel == str_pkg::RL_OVF) begin
            s.counter = q.preset;
        end else if (tick) begin
            s.counter = q.counter + 16'h0001;
        end

        if (cap) begin
            s.preset = q.counter;
        end

        // Software writes; flags keep a concurrent set
        if (wr) begin
            case (widx)
                str_pkg::IDX_COMPARE_CAPTURE_ENABLE:  s.compare_capture_enable          = pwdata[7:0];
                str_pkg::IDX_CC1L:  s.ccr[0]        = pwdata[7:0];
                str_pkg::IDX_CC1H:  s.ccr[1]        = pwdata[7:0];
                str_pkg::IDX_CC2L:  s.ccr[2]        = pwdata[7:0];
                str_pkg::IDX_CC2H:  s.ccr[3]        = pwdata[7:0];
                str_pkg::IDX_CC3L:  s.ccr[4]        = pwdata[7:0];
                str_pkg::IDX_CC3H:  s.ccr[5]        = pwdata[7:0];
                str_pkg::IDX_CTRL:  s.ctrl          = pwdata[7:0];
                str_pkg::IDX_PRE_L: s.preset[7:0]   = pwdata[7:0];
                str_pkg::IDX_PRE_H: s.preset[15:8]  = pwdata[7:0];
                str_pkg::IDX_CNT_L: s.counter[7:0]  = pwdata[7:0];
                str_pkg::IDX_CNT_H: s.counter[15:8] = pwdata[7:0];
                str_pkg::IDX_MASK:  s.mask          = pwdata[1:0];
                str_pkg::IDX_IEN:   s.ien           = pwdata[7:0];
                str_pkg::IDX_BITOP: s.ctrl[pwdata[2:0]] = pwdata[3];
                str_pkg::IDX_INTERRUPT_REQUEST_CONTROL: begin
                    s.overflow_flag        = pwdata[str_pkg::IB_OVF];
                    s.external_reload_flag = pwdata[str_pkg::IB_EXT];
                end
                default: ;
            endcase
        end

        s.overflow_flag        = s.overflow_flag | ovf;
        s.external_reload_flag = s.external_reload_flag | ext_set;

        // Status clears only the bits that the read returned
        if (rd && widx == str_pkg::IDX_STAT) begin
            s.stat = q.stat & ~q.prdata[1:0];
        end
        s.stat[str_pkg::SB_OVF] = s.stat[str_pkg::SB_OVF] | ovf;
        s.stat[str_pkg::SB_EXT] = s.stat[str_pkg::SB_EXT] | ext_set;
        s.irq = |(s.stat & s.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= s;
        end
    end

    assign prdata           = q.prdata;
    assign pready           = q.pready;
    assign pslverr          = q.pslverr;
    assign irq              = q.irq;
    assign count_value      = q.counter;
    assign compare_mode_one = q.ctrl[str_pkg::CB_CMP];

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic quiet;
    assign quiet = ~wr_cnt & ~do_trig_rl;

    // Event: edge seen at one machine cycle, counted at the next
    sequence seq_ev_seen;
        ev_edge;
    endsequence

    sequence seq_ev_due;
        mc && quiet && isel == str_pkg::IS_EVENT && q.counter != str_pkg::CNT_ALL1;
    endsequence

    // Trigger: edge seen at one machine cycle, reload at the next
    sequence seq_trg_seen;
        trg_edge;
    endsequence

    sequence seq_trg_due;
        mc && !wr_cnt && rsel == str_pkg::RL_TRIG;
    endsequence

    a_stop_holds: assert property (
        (isel == str_pkg::IS_STOP) && quiet |=> $stable(q.counter))
        else $error("counter moved while stopped");

    a_timer_rate: assert property (
        mc && isel == str_pkg::IS_TIMER && !q.ctrl[str_pkg::CB_PS] && quiet
        && q.counter != str_pkg::CNT_ALL1
        |=> q.counter == $past(q.counter) + 16'h0001)
        else $error("timer did not step on machine cycle");

    a_prescale_skip: assert property (
        mc && isel == str_pkg::IS_TIMER && q.ctrl[str_pkg::CB_PS] && !q.pre && quiet
        |=> $stable(q.counter))
        else $error("prescaled timer stepped early");

    a_gate_low_stops: assert property (
        isel == str_pkg::IS_GATED && !pins.count_gate_pin && quiet
        |=> $stable(q.counter))
        else $error("gated timer counted with gate low");

    a_event_next_mc: assert property (
        seq_ev_seen ##12 seq_ev_due
        |=> q.counter == $past(q.counter) + 16'h0001)
        else $error("event count not applied next machine cycle");

    a_ovf_sets_flag: assert property (
        ovf |=> q.overflow_flag && q.stat[str_pkg::SB_OVF])
        else $error("overflow flag not set on rollover");

    a_ovf_reload: assert property (
        ovf && rsel == str_pkg::RL_OVF && quiet
        |=> q.counter == $past(q.preset))
        else $error("overflow reload missed");

    a_trig_reload: assert property (
        seq_trg_seen ##12 seq_trg_due |=> q.counter == $past(q.preset))
        else $error("trigger reload not on next machine cycle");

    a_ext_flag: assert property (
        trg_edge && q.ien[str_pkg::EB_EXT] |=> q.external_reload_flag)
        else $error("reload flag not set on trigger edge");

    a_irq_level: assert property (
        irq == |(q.stat & q.mask))
        else $error("interrupt level does not follow status");

    a_apb_answer: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    // Counting rates and machine cycle
    a_prescale_step: assert property (
        mc && isel == str_pkg::IS_TIMER && q.ctrl[str_pkg::CB_PS] && q.pre && quiet
        && q.counter != str_pkg::CNT_ALL1
        |=> q.counter == $past(q.counter) + 16'h0001)
        else $error("prescaled timer missed its step");

    a_pre_toggle: assert property (
        mc |=> q.pre != $past(q.pre))
        else $error("prescaler did not toggle");

    a_mc_period: assert property (
        q.div <= str_pkg::MC_LAST)
        else $error("machine-cycle divider out of range");

    a_gate_high_counts: assert property (
        mc && isel == str_pkg::IS_GATED && pins.count_gate_pin && ps_ok && quiet
        && q.counter != str_pkg::CNT_ALL1
        |=> q.counter == $past(q.counter) + 16'h0001)
        else $error("gated timer missed a step with gate high");

    a_event_wait: assert property (
        ev_edge && quiet |=> $stable(q.counter))
        else $error("event counted in the detecting cycle");

    a_ev_pend_clear: assert property (
        mc && !ev_edge |=> !q.ev_pend)
        else $error("event pending left set");

    a_rl_pend_clear: assert property (
        mc && !trg_edge |=> !q.rl_pend)
        else $error("reload pending left set");

    // Flags, status and interrupt
    a_ext_status: assert property (
        ext_set |=> q.stat[str_pkg::SB_EXT])
        else $error("reload status not set on trigger edge");

    a_ovf_flag_hold: assert property (
        q.overflow_flag && !(wr && widx == str_pkg::IDX_INTERRUPT_REQUEST_CONTROL) |=> q.overflow_flag)
        else $error("overflow flag dropped without software");

    a_ext_flag_hold: assert property (
        q.external_reload_flag && !(wr && widx == str_pkg::IDX_INTERRUPT_REQUEST_CONTROL)
        |=> q.external_reload_flag)
        else $error("reload flag dropped without software");

    a_flag_sw_clear: assert property (
        wr && widx == str_pkg::IDX_INTERRUPT_REQUEST_CONTROL && !pwdata[str_pkg::IB_OVF] && !ovf
        |=> !q.overflow_flag)
        else $error("overflow flag not cleared by software");

    a_stat_clear: assert property (
        rd && widx == str_pkg::IDX_STAT && !ovf && !ext_set
        |=> (q.stat & $past(q.prdata[1:0])) == 2'h0)
        else $error("status bits not cleared by read");

    a_mask_hold: assert property (
        !wr |=> $stable(q.mask))
        else $error("mask changed without a write");

    a_ien_hold: assert property (
        !wr |=> $stable(q.ien))
        else $error("reload enable changed without a write");

    // Capture, preset and control
    a_cap_copy: assert property (
        cap && !wr |=> q.preset == $past(q.counter))
        else $error("capture did not copy the counter");

    a_preset_hold: assert property (
        !wr && !cap |=> $stable(q.preset))
        else $error("preset changed without write or capture");

    a_cnt_write: assert property (
        wr && widx == str_pkg::IDX_CNT_L |=> q.counter[7:0] == $past(pwdata[7:0]))
        else $error("counter low byte write lost");

    a_ctrl_only_sw: assert property (
        !wr |=> $stable(q.ctrl))
        else $error("control changed without a write");

    a_bitop_write: assert property (
        wr && widx == str_pkg::IDX_BITOP
        |=> q.ctrl[$past(pwdata[2:0])] == $past(pwdata[3]))
        else $error("single control bit write lost");

    // Register bus
    a_apb_refused: assert property (
        psel && !penable && !hit |=> pslverr && prdata == 32'h00000000)
        else $error("refused access not flagged");

    a_apb_read_ctrl: assert property (
        psel && !penable && !pwrite && hit && widx == str_pkg::IDX_CTRL
        |=> prdata == {24'h000000, $past(q.ctrl)})
        else $error("control read data wrong");

endmodule : str_timer

// ---- logic/str_pkg.sv ----
// Constants, register map and carrier types of the sixteen-bit timer.
// Assumes a 20 MHz pclk that also stands for the oscillator.
package str_pkg;

    // Machine cycle is twelve clocks
    localparam int unsigned MC_DIV  = 12;
    localparam logic [3:0]  MC_LAST = 4'(MC_DIV - 1);

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_INTERRUPT_REQUEST_CONTROL  = 10'h0c0;
    localparam logic [9:0] IDX_COMPARE_CAPTURE_ENABLE   = 10'h0c1;
    localparam logic [9:0] IDX_CC1L   = 10'h0c2;
    localparam logic [9:0] IDX_CC1H   = 10'h0c3;
    localparam logic [9:0] IDX_CC2L   = 10'h0c4;
    localparam logic [9:0] IDX_CC2H   = 10'h0c5;
    localparam logic [9:0] IDX_CC3L   = 10'h0c6;
    localparam logic [9:0] IDX_CC3H   = 10'h0c7;
    localparam logic [9:0] IDX_CTRL   = 10'h0c8;
    localparam logic [9:0] IDX_PRE_L  = 10'h0ca;
    localparam logic [9:0] IDX_PRE_H  = 10'h0cb;
    localparam logic [9:0] IDX_CNT_L  = 10'h0cc;
    localparam logic [9:0] IDX_CNT_H  = 10'h0cd;
    localparam logic [9:0] IDX_STAT   = 10'h0d0;
    localparam logic [9:0] IDX_MASK   = 10'h0d1;
    localparam logic [9:0] IDX_IEN    = 10'h0d2;
    localparam logic [9:0] IDX_BITOP  = 10'h0d3;

    // Timer control fields
    localparam int CB_IS_LO = 0;
    localparam int CB_IS_HI = 1;
    localparam int CB_CMP   = 2;
    localparam int CB_RL_LO = 3;
    localparam int CB_RL_HI = 4;
    localparam int CB_EDGE  = 6;
    localparam int CB_PS    = 7;

    // Input select and reload select codes
    localparam logic [1:0] IS_STOP  = 2'h0;
    localparam logic [1:0] IS_TIMER = 2'h1;
    localparam logic [1:0] IS_EVENT = 2'h2;
    localparam logic [1:0] IS_GATED = 2'h3;
    localparam logic [1:0] RL_OVF   = 2'h2;
    localparam logic [1:0] RL_TRIG  = 2'h3;

    // Flag positions
    localparam int IB_OVF = 6;
    localparam int IB_EXT = 7;
    localparam int EB_EXT = 3;
    localparam int SB_OVF = 0;
    localparam int SB_EXT = 1;

    // Compare/capture enable: channel-0 capture code in bits 1:0
    localparam logic [1:0] CE_CAP0 = 2'h1;

    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] CNT_ALL1 = 16'hffff;

    typedef struct packed {
        logic count_gate_pin;
        logic reload_trigger_pin;
        logic channel_zero_pin;
    } str_pins_t;

    typedef struct packed {
        logic [3:0]      div;
        logic            pre;
        logic            cnt_smp;
        logic            trg_smp;
        logic            cc0_smp;
        logic            ev_pend;
        logic            rl_pend;
        logic [15:0]     counter;
        logic [15:0]     preset;
        logic [7:0]      ctrl;
        logic            overflow_flag;
        logic            external_reload_flag;
        logic [7:0]      compare_capture_enable;
        logic [5:0][7:0] ccr;
        logic [7:0]      ien;
        logic [1:0]      stat;
        logic [1:0]      mask;
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
        logic            irq;
    } str_state_t;

endpackage : str_pkg

// ---- tb/str_pin_model.sv ----
// Far-side pin model: count/gate, reload trigger and channel-0 pins.
// Assumes pclk and presetn shared with the timer; levels move once a machine cycle.
`timescale 1ns/100ps

module str_pin_model (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  str_pkg::str_pins_t want,
    output str_pkg::str_pins_t pins
);
    logic [3:0] phase;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 4'h0;
            pins  <= '0;
        end else begin
            phase <= (phase == 4'hb) ? 4'h0 : phase + 4'h1;
            // New level mid machine cycle, so each level is held at least twelve clocks
            if (phase == 4'h5) pins <= want;
        end
    end
endmodule : str_pin_model

// ---- tb/test_str_timer.sv ----
// Self-checking bench of the sixteen-bit timer over APB and its pins.
// Assumes the pin model and the timer share pclk and presetn.
`timescale 1ns/100ps

module test_str_timer;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               irq;
    logic               compare_mode_one;
    logic [15:0]        count_value;
    logic [15:0]        lfsr_st = 16'hacaf;
    str_pkg::str_pins_t want = '0;
    str_pkg::str_pins_t pins;
    int                 n_fail = 0;
    int                 n_compared = 0;
    int                 cycles = 0;
    logic [31:0]        r;
    logic               e;
    logic [15:0]        p;

    always #25 pclk = ~pclk;

    str_pin_model u_str_pin_model (.pclk(pclk), .presetn(presetn), .want(want), .pins(pins));
    str_timer u_str_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .pins(pins), .count_value(count_value),
        .compare_mode_one(compare_mode_one));

    function automatic logic [15:0] exp_count(input logic [15:0] c, input int clk, input int ps);
        return c + 16'(clk / (12 * (ps + 1)));
    endfunction : exp_count

    function automatic logic [15:0] nxt();
        lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
        return lfsr_st;
    endfunction : nxt

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] x);
        n_compared++;
        if (got !== x) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, x);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc

    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'h0};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [31:0] x);
        apb(1'b0, idx, 8'h00);
        chk(r, x);
    endtask : rd

    // Counter advance over a span of clocks at the given prescale
    task automatic rate(input int clk, input int ps);
        logic [15:0] c0;
        #1;
        c0 = count_value;
        cyc(clk);
        chk({16'h0, count_value}, {16'h0, exp_count(c0, clk, ps)});
    endtask : rate

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(str_pkg::IDX_CTRL, 32'h0);
        rd(str_pkg::IDX_CNT_L, 32'h0);
        apb(1'b0, 10'h0e0, 8'h00);
        chk({31'h0, e}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            p = nxt();
            wr(str_pkg::IDX_PRE_L, p[7:0]);
            rd(str_pkg::IDX_PRE_L, {24'h0, p[7:0]});
        end
        wr(str_pkg::IDX_CTRL, 8'h01);
        rate(60, 0);
        wr(str_pkg::IDX_CTRL, 8'h81);
        rate(48, 1);
        wr(str_pkg::IDX_CTRL, 8'h00);
        cyc(2);
        rate(48, 99);
        p = nxt();
        wr(str_pkg::IDX_CNT_L, p[7:0]);
        cyc(1);
        chk({24'h0, count_value[7:0]}, {24'h0, p[7:0]});
        wr(str_pkg::IDX_CTRL, 8'h02);
        cyc(1);
        p = count_value;
        for (int k = 0; k < 3; k++) begin
            want.count_gate_pin = 1'b1;
            cyc(24);
            want.count_gate_pin = 1'b0;
            cyc(36);
        end
        chk({16'h0, count_value}, {16'h0, p + 16'h3});
        wr(str_pkg::IDX_CTRL, 8'h03);
        rate(48, 99);
        want.count_gate_pin = 1'b1;
        cyc(24);
        rate(48, 0);
        want.count_gate_pin = 1'b0;
        wr(str_pkg::IDX_CTRL, 8'h00);
        wr(str_pkg::IDX_MASK, 8'h03);
        p = nxt() & 16'h7fff;
        wr(str_pkg::IDX_PRE_L, p[7:0]);
        wr(str_pkg::IDX_PRE_H, p[15:8]);
        wr(str_pkg::IDX_CNT_L, 8'hff);
        wr(str_pkg::IDX_CNT_H, 8'hff);
        wr(str_pkg::IDX_CTRL, 8'h11);
        for (int k = 0; k < 40 && irq !== 1'b1; k++) cyc(1);
        chk({16'h0, count_value}, {16'h0, p});
        wr(str_pkg::IDX_CTRL, 8'h00);
        rd(str_pkg::IDX_INTERRUPT_REQUEST_CONTROL, 32'h40);
        rd(str_pkg::IDX_STAT, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(str_pkg::IDX_INTERRUPT_REQUEST_CONTROL, 8'h00);
        rd(str_pkg::IDX_INTERRUPT_REQUEST_CONTROL, 32'h0);
        wr(str_pkg::IDX_IEN, 8'h08);
        wr(str_pkg::IDX_CTRL, 8'h1a);
        wr(str_pkg::IDX_CNT_L, ~p[7:0]);
        want.reload_trigger_pin = 1'b1;
        cyc(36);
        want.reload_trigger_pin = 1'b0;
        cyc(36);
        chk({16'h0, count_value}, {16'h0, p});
        chk({31'h0, irq}, 32'h1);
        rd(str_pkg::IDX_INTERRUPT_REQUEST_CONTROL, 32'h80);
        rd(str_pkg::IDX_STAT, 32'h2);
        wr(str_pkg::IDX_BITOP, 8'h0a);
        cyc(1);
        chk({31'h0, compare_mode_one}, 32'h1);
        rd(str_pkg::IDX_CTRL, 32'h1e);
        wr(str_pkg::IDX_BITOP, 8'h02);
        cyc(1);
        chk({31'h0, compare_mode_one}, 32'h0);
        wr(str_pkg::IDX_CTRL, 8'h40);
        wr(str_pkg::IDX_COMPARE_CAPTURE_ENABLE, 8'h01);
        wr(str_pkg::IDX_CNT_L, 8'h5a);
        want.channel_zero_pin = 1'b1;
        cyc(36);
        rd(str_pkg::IDX_PRE_L, 32'h5a);
        rd(str_pkg::IDX_PRE_H, {24'h0, p[15:8]});
        wr(str_pkg::IDX_CTRL, 8'h00);
        wr(str_pkg::IDX_CNT_L, 8'ha5);
        want.channel_zero_pin = 1'b0;
        cyc(36);
        rd(str_pkg::IDX_PRE_L, 32'ha5);
        wrap_up();
    end
endmodule : test_str_timer
